// *** core/ocd_defines.vh ***
// Opcode field positions, operation codes, timing and register map for the decoder core.
// Assumes inclusion by the single core design file; definitions only.
`ifndef OCD_DEFINES_VH
`define OCD_DEFINES_VH
// Instruction field positions
`define OCD_PFX_HI 13
`define OCD_PFX_LO 12
`define OCD_OP_HI 11
`define OCD_OP_LO 8
`define OCD_DST_BIT 7
`define OCD_BIT_HI 9
`define OCD_BIT_LO 7
`define OCD_PTR_SEL_BIT 2
// Prefix groups
`define OCD_PFX_BYTE 2'h0
`define OCD_PFX_BIT 2'h1
`define OCD_PFX_LIT 2'h3
// Byte group codes (prefix 00)
`define OCD_OP_MOVWF 4'h0
`define OCD_OP_CLR 4'h1
`define OCD_OP_SUBWF 4'h2
`define OCD_OP_DECF 4'h3
`define OCD_OP_IORWF 4'h4
`define OCD_OP_ANDWF 4'h5
`define OCD_OP_XORWF 4'h6
`define OCD_OP_ADDF 4'h7
`define OCD_OP_MOVF 4'h8
`define OCD_OP_COMF 4'h9
`define OCD_OP_INCF 4'ha
`define OCD_OP_DECSZ 4'hb
`define OCD_OP_RRF 4'hc
`define OCD_OP_RLF 4'hd
`define OCD_OP_SWAPF 4'he
`define OCD_OP_INCSZ 4'hf
// Prefix 11 codes
`define OCD_OP_LDACC 4'h0
`define OCD_OP_LDPCH 4'h1
`define OCD_OP_LSLF 4'h5
`define OCD_OP_LSRF 4'h6
`define OCD_OP_ASRF 4'h7
`define OCD_OP_IORLW 4'h8
`define OCD_OP_ANDLW 4'h9
`define OCD_OP_XORLW 4'ha
`define OCD_OP_SUBB 4'hb
`define OCD_OP_SUBLW 4'hc
`define OCD_OP_ADDC 4'hd
`define OCD_OP_ADDLW 4'he
// Instruction cycle phases
`define OCD_PHASES 2'h3
// AXI4-Lite register byte addresses
`define OCD_REG_INSN 4'h0
`define OCD_REG_CTRL 4'h4
`define OCD_REG_RDATA 4'h8
`define OCD_REG_ACC 4'hc
// Control bits and response codes
`define OCD_CTRL_GO 0
`define OCD_RESP_OKAY 2'h0
`define OCD_RESP_SLVERR 2'h2
`endif

// *** core/ocd_core.v ***
// Instruction decoder and execute control for an 8-bit accumulator core.
// Assumes software feeds instruction words and file-register read data over
// AXI4-Lite, and collects the write-back and strobes from the FILE_* ports.
`include "ocd_defines.vh"

// Summary of operation
// [RULE1] File ops read, modify, then write back
// [RULE2] Addressed register always read first
// [RULE3] d=0 to accumulator, d=1 to file
// [RULE4] File address is seven bits wide
// [RULE5] Don't-care opcode bits are ignored
// [RULE6] Bit clear/set, three-bit position, no flags
// [RULE7] Pointer select picks pointer zero or one
// [RULE8] Two-bit mode: pre/post increment/decrement
// [RULE9] Add and add-with-carry update C, HC, Z
// [RULE10] AND, OR, XOR with file: zero only
// [RULE11] Rotates touch carry; shifts carry and zero
// [RULE12] Subtract and subtract-borrow update C, HC, Z
// [RULE13] Inc/dec skip on zero, no flags
// [RULE14] Bit test skips on clear or set
// [RULE15] Add literal updates C, HC, Z
// [RULE16] Literal minus accumulator updates C, HC, Z
// [RULE17] Literal logic ops affect zero only
// [RULE18] Load PC-high and accumulator literals, no flags
// [RULE19] One 14-bit word holds opcode and operands
// [RULE20] Instruction cycle is four clock periods
// [RULE21] True skip runs second cycle as no-op
// [RULE22] Z on zero, C bit7, HC nibble
module ocd_core (
  input wire MCLK,
  input wire SYS_RST,
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg [6:0] FILE_ADDR,
  output reg FILE_RD,
  output reg FILE_WR,
  output reg [7:0] FILE_WDATA,
  output reg [6:0] PC_HIGH_LATCH,
  output reg PTR_SEL,
  output reg [1:0] PTR_UPDATE_MODE
);

  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************

  // Nine-bit add with carry in; bit 8 is the carry out of bit 7
  function [8:0] ocd_add;
    input [7:0] a;
    input [7:0] b;
    input cin;
    begin
      ocd_add = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
  endfunction

  // Carry out of the low nibble for the same add
  function ocd_half;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [4:0] s;
    begin
      s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ocd_half = s[4];
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  reg [13:0] insn_q; // Latched instruction word
  reg [7:0] rdata_q; // File register read data from software
  reg [7:0] acc_q; // Working accumulator
  reg carry_q; // Carry flag
  reg half_carry_flag_q; // Half-carry flag
  reg zero_q; // Zero flag
  reg busy_q; // Instruction in progress
  reg [1:0] phase_q; // Phase inside an instruction cycle
  reg skip_q; // Second, no-op cycle pending
  reg aw_hold_q; // Write address accepted, waiting for data
  reg [3:0] aw_addr_q; // Held write address
  reg w_hold_q; // Write data accepted, waiting for address
  reg [31:0] w_data_q; // Held write data

  // ****************************************************************
  // Decode and execute (combinational)
  // ****************************************************************

  wire [1:0] pfx = insn_q[`OCD_PFX_HI:`OCD_PFX_LO]; // [RULE19]
  wire [3:0] op = insn_q[`OCD_OP_HI:`OCD_OP_LO];
  wire dst = insn_q[`OCD_DST_BIT];
  wire [6:0] faddr = insn_q[6:0]; // [RULE4]
  wire [7:0] lit = insn_q[7:0];
  wire [2:0] bpos = insn_q[`OCD_BIT_HI:`OCD_BIT_LO];
  wire [7:0] bmask = 8'h01 << bpos; // [RULE6]

  reg [7:0] res; // Operation result
  reg to_file; // Result goes to the file register
  reg to_acc; // Result goes to the accumulator
  reg uses_file; // Instruction names a file register
  reg upd_c, upd_hc, upd_z; // Which flags to update
  reg new_c, new_hc; // Flag values
  reg skip_cond; // Skip the next instruction
  reg ld_pch; // Load the program counter high latch
  reg [8:0] sum; // Wide sum scratch

  always @* begin
    res = 8'h00;
    to_file = 1'b0;
    to_acc = 1'b0;
    uses_file = 1'b0;
    upd_c = 1'b0;
    upd_hc = 1'b0;
    upd_z = 1'b0;
    new_c = carry_q;
    new_hc = half_carry_flag_q;
    skip_cond = 1'b0;
    ld_pch = 1'b0;
    sum = 9'h000;
    case (pfx)
      `OCD_PFX_BYTE: begin
        uses_file = 1'b1; // [RULE1] [RULE2]
        to_file = dst; // [RULE3]
        to_acc = ~dst; // [RULE3]
        case (op)
          `OCD_OP_MOVWF: begin
            // d=0 encodings are control forms, left undecoded here
            res = acc_q;
            to_acc = 1'b0;
          end
          `OCD_OP_CLR: begin
            // Low bits of the accumulator form are ignored
            res = 8'h00; // [RULE5]
            uses_file = dst; // [RULE1] Accumulator form names no file
            upd_z = 1'b1;
          end
          `OCD_OP_SUBWF: begin
            sum = ocd_add(rdata_q, ~acc_q, 1'b1); // [RULE12]
            res = sum[7:0];
            new_c = sum[8]; // [RULE22]
            new_hc = ocd_half(rdata_q, ~acc_q, 1'b1);
            {upd_c, upd_hc, upd_z} = 3'b111;
          end
          `OCD_OP_DECF: begin
            res = rdata_q - 8'h01;
            upd_z = 1'b1;
          end
          `OCD_OP_IORWF: begin
            res = acc_q | rdata_q; // [RULE10]
            upd_z = 1'b1;
          end
          `OCD_OP_ANDWF: begin
            res = acc_q & rdata_q; // [RULE10]
            upd_z = 1'b1;
          end
          `OCD_OP_XORWF: begin
            res = acc_q ^ rdata_q; // [RULE10]
            upd_z = 1'b1;
          end
          `OCD_OP_ADDF: begin
            sum = ocd_add(acc_q, rdata_q, 1'b0); // [RULE9]
            res = sum[7:0];
            new_c = sum[8];
            new_hc = ocd_half(acc_q, rdata_q, 1'b0);
            {upd_c, upd_hc, upd_z} = 3'b111;
          end
          `OCD_OP_MOVF: begin
            res = rdata_q;
            upd_z = 1'b1;
          end
          `OCD_OP_COMF: begin
            res = ~rdata_q;
            upd_z = 1'b1;
          end
          `OCD_OP_INCF: begin
            res = rdata_q + 8'h01;
            upd_z = 1'b1;
          end
          `OCD_OP_DECSZ: begin
            res = rdata_q - 8'h01; // [RULE13]
            skip_cond = (res == 8'h00);
          end
          `OCD_OP_RRF: begin
            res = {carry_q, rdata_q[7:1]}; // [RULE11]
            new_c = rdata_q[0];
            upd_c = 1'b1;
          end
          `OCD_OP_RLF: begin
            res = {rdata_q[6:0], carry_q}; // [RULE11]
            new_c = rdata_q[7];
            upd_c = 1'b1;
          end
          `OCD_OP_SWAPF: begin
            res = {rdata_q[3:0], rdata_q[7:4]};
          end
          default: begin
            res = rdata_q + 8'h01; // [RULE13]
            skip_cond = (res == 8'h00);
          end
        endcase
      end
      `OCD_PFX_BIT: begin
        uses_file = 1'b1; // [RULE2]
        case (op[3:2])
          2'h0: begin
            res = rdata_q & ~bmask; // [RULE6]
            to_file = 1'b1;
          end
          2'h1: begin
            res = rdata_q | bmask; // [RULE6]
            to_file = 1'b1;
          end
          2'h2: skip_cond = ((rdata_q & bmask) == 8'h00); // [RULE14]
          default: skip_cond = ((rdata_q & bmask) != 8'h00); // [RULE14]
        endcase
      end
      `OCD_PFX_LIT: begin
        case (op)
          `OCD_OP_LDACC: begin
            res = lit; // [RULE18]
            to_acc = 1'b1;
          end
          `OCD_OP_LDPCH: ld_pch = insn_q[7]; // [RULE18]
          `OCD_OP_LSLF, `OCD_OP_LSRF, `OCD_OP_ASRF: begin
            uses_file = 1'b1;
            to_file = dst;
            to_acc = ~dst;
            {upd_c, upd_z} = 2'b11; // [RULE11]
            if (op == `OCD_OP_LSLF) begin
              res = {rdata_q[6:0], 1'b0};
              new_c = rdata_q[7];
            end else begin
              res = {(op == `OCD_OP_ASRF) & rdata_q[7], rdata_q[7:1]};
              new_c = rdata_q[0];
            end
          end
          `OCD_OP_IORLW, `OCD_OP_ANDLW, `OCD_OP_XORLW: begin
            to_acc = 1'b1;
            upd_z = 1'b1; // [RULE17]
            if (op == `OCD_OP_IORLW) res = acc_q | lit;
            else if (op == `OCD_OP_ANDLW) res = acc_q & lit;
            else res = acc_q ^ lit;
          end
          `OCD_OP_SUBB: begin
            uses_file = 1'b1;
            to_file = dst;
            to_acc = ~dst;
            sum = ocd_add(rdata_q, ~acc_q, carry_q); // [RULE12]
            res = sum[7:0];
            new_c = sum[8];
            new_hc = ocd_half(rdata_q, ~acc_q, carry_q);
            {upd_c, upd_hc, upd_z} = 3'b111;
          end
          `OCD_OP_SUBLW: begin
            to_acc = 1'b1;
            sum = ocd_add(lit, ~acc_q, 1'b1); // [RULE16]
            res = sum[7:0];
            new_c = sum[8];
            new_hc = ocd_half(lit, ~acc_q, 1'b1);
            {upd_c, upd_hc, upd_z} = 3'b111;
          end
          `OCD_OP_ADDC, `OCD_OP_ADDLW: begin
            uses_file = (op == `OCD_OP_ADDC);
            to_file = uses_file & dst;
            to_acc = ~(uses_file & dst);
            sum = ocd_add(acc_q, uses_file ? rdata_q : lit, uses_file & carry_q); // [RULE9] [RULE15]
            res = sum[7:0];
            new_c = sum[8];
            new_hc = ocd_half(acc_q, uses_file ? rdata_q : lit, uses_file & carry_q);
            {upd_c, upd_hc, upd_z} = 3'b111;
          end
          default: res = 8'h00;
        endcase
      end
      default: res = 8'h00;
    endcase
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************

  // Acting only on held halves keeps an unmapped address from aliasing onto INSN
  wire [3:0] wa = aw_addr_q; // Held write address
  wire [31:0] wd = w_data_q; // Held write data
  wire wr_fire = aw_hold_q & w_hold_q & ~S_AXI_BVALID; // Both halves held, no pending answer
  wire wsel_insn = wr_fire & (wa == `OCD_REG_INSN) & ~busy_q;
  wire wsel_rd = wr_fire & (wa == `OCD_REG_RDATA);
  wire go = wr_fire & (wa == `OCD_REG_CTRL) & wd[`OCD_CTRL_GO] & ~busy_q;

  // Write channels accept address and data in either order
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `OCD_RESP_OKAY;
      aw_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
    end else begin
      S_AXI_AWREADY <= ~aw_hold_q & ~S_AXI_AWREADY & ~S_AXI_BVALID;
      S_AXI_WREADY <= ~w_hold_q & ~S_AXI_WREADY & ~S_AXI_BVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= (S_AXI_AWADDR[31:4] == 28'h0000000) ? S_AXI_AWADDR[3:0] : 4'h1;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_hold_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
      end
      if (aw_hold_q & w_hold_q & ~S_AXI_BVALID) begin
        // Unaligned or out-of-range address answers SLVERR
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr_q[1:0] == 2'h0) ? `OCD_RESP_OKAY : `OCD_RESP_SLVERR;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `OCD_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `OCD_RESP_OKAY;
        case (S_AXI_ARADDR)
          {28'h0000000, `OCD_REG_INSN}: S_AXI_RDATA <= {18'h00000, insn_q};
          {28'h0000000, `OCD_REG_CTRL}: S_AXI_RDATA <= {30'h00000000, skip_q, busy_q};
          {28'h0000000, `OCD_REG_RDATA}: S_AXI_RDATA <= {24'h000000, rdata_q};
          {28'h0000000, `OCD_REG_ACC}: S_AXI_RDATA <= {21'h000000, zero_q, half_carry_flag_q, carry_q, acc_q};
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `OCD_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Instruction cycle sequencer
  // ****************************************************************

  // Phase 0 reads the file register, phase 3 writes back; software loads the
  // read data before GO, so the strobe reports the access rather than fetching.
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      insn_q <= 14'h0000;
      rdata_q <= 8'h00;
      acc_q <= 8'h00;
      carry_q <= 1'b0;
      half_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
      busy_q <= 1'b0;
      phase_q <= 2'h0;
      skip_q <= 1'b0;
      FILE_ADDR <= 7'h00;
      FILE_RD <= 1'b0;
      FILE_WR <= 1'b0;
      FILE_WDATA <= 8'h00;
      PC_HIGH_LATCH <= 7'h00;
      PTR_SEL <= 1'b0;
      PTR_UPDATE_MODE <= 2'h0;
    end else begin
      FILE_RD <= 1'b0;
      FILE_WR <= 1'b0;
      if (wsel_insn) insn_q <= wd[13:0]; // [RULE19]
      if (wsel_rd & ~busy_q) rdata_q <= wd[7:0];
      if (go) begin
        busy_q <= 1'b1;
        phase_q <= 2'h0;
        FILE_ADDR <= faddr; // [RULE4]
        FILE_RD <= uses_file; // [RULE2]
        PTR_SEL <= insn_q[`OCD_PTR_SEL_BIT]; // [RULE7]
        PTR_UPDATE_MODE <= insn_q[1:0]; // [RULE8]
      end else if (busy_q) begin
        phase_q <= phase_q + 2'h1; // [RULE20]
        if (phase_q == `OCD_PHASES) begin
          if (skip_q) begin
            // Second cycle of a taken skip does nothing
            skip_q <= 1'b0; // [RULE21]
            busy_q <= 1'b0;
          end else begin
            FILE_WR <= to_file; // [RULE1] [RULE3]
            if (to_file) FILE_WDATA <= res; // Held between writes
            if (to_acc) acc_q <= res; // [RULE3]
            if (upd_c) carry_q <= new_c; // [RULE22]
            if (upd_hc) half_carry_flag_q <= new_hc;
            if (upd_z) zero_q <= (res == 8'h00); // [RULE22]
            if (ld_pch) PC_HIGH_LATCH <= lit[6:0]; // [RULE18]
            skip_q <= skip_cond; // [RULE13] [RULE14] [RULE21]
            busy_q <= skip_cond;
          end
        end
      end
    end
  end

endmodule // ocd_core

// *** verification/ocd_core_properties.sv ***
// Checker for the decoder core: file strobe timing and register bus handshakes.
// Assumes it is bound to the core and sees only the core's ports.
// ********************
// Checker module
// ********************
module ocd_checker (
  input wire MCLK,
  input wire SYS_RST,
  input wire S_AXI_AWREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [6:0] FILE_ADDR,
  input wire FILE_RD,
  input wire FILE_WR,
  input wire [7:0] FILE_WDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] gap_q; // Cycles since the last file read, saturating
  logic [6:0] rd_addr_q; // Address of the last file read
  // Track the last read so a write can be tied to it; saturating keeps a stray write visible
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gap_q <= 4'hf;
      rd_addr_q <= 7'h0;
    end else if (FILE_RD) begin
      gap_q <= 4'h0;
      rd_addr_q <= FILE_ADDR;
    end else if (gap_q != 4'hf) begin
      gap_q <= gap_q + 4'h1;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  rd_pulse_a: assert property (FILE_RD |=> !FILE_RD) else $error("file read strobe too long");
  wr_pulse_a: assert property (FILE_WR |=> !FILE_WR) else $error("file write strobe too long");
  wr_after_rd_a: assert property (FILE_WR |-> !FILE_RD && gap_q <= 4'h5)
    else $error("file write without a preceding read");
  wr_same_addr_a: assert property (FILE_WR |-> FILE_ADDR == rd_addr_q)
    else $error("write address differs from read address");
  wdata_hold_a: assert property ($changed(FILE_WDATA) |-> FILE_WR) else $error("write data moved");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("late read data");
  aw_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("address ready held");
  ar_refused_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while pending");
  cover property (FILE_RD ##[1:5] FILE_WR);
  cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule // ocd_checker

bind ocd_core ocd_checker i_ocd_checker (.MCLK, .SYS_RST, .S_AXI_AWREADY, .S_AXI_BRESP, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
  .S_AXI_RREADY, .FILE_ADDR, .FILE_RD, .FILE_WR, .FILE_WDATA);

// *** verification/ocd_file_model.sv ***
// File register side model: counts read and write strobes, keeps the last write.
// Assumes the core's strobes are one-cycle pulses on the core clock.
// ********************
// File side model
// ********************
module ocd_file_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [6:0] file_addr,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  output int rd_cnt,
  output int wr_cnt,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Count every strobe so a missing or doubled access shows in the totals
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_cnt <= 0;
      wr_cnt <= 0;
      wr_addr <= 7'h0;
      wr_data <= 8'h0;
    end else begin
      if (file_rd) begin
        rd_cnt <= rd_cnt + 1;
      end
      if (file_wr) begin
        wr_cnt <= wr_cnt + 1;
        wr_addr <= file_addr;
        wr_data <= file_wdata;
      end
    end
  end
endmodule // ocd_file_model

// *** verification/ocd_core_bench.sv ***
// Self-checking bench for the decoder core, with a reference model of the core.
// Assumes the register map and busy/skip status bits described for the core.
module ocd_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Stimulus and state
  // ********************
  logic mclk = 0;
  logic sys_rst = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, file_rd, file_wr, ptr_sel;
  wire [1:0] bresp, rresp, ptr_mode;
  wire [31:0] rdata;
  wire [6:0] file_addr, pch, wr_addr;
  wire [7:0] file_wdata, wr_data;
  int rd_cnt, wr_cnt;
  int miscompares = 0, n_compared = 0, cycles = 0, seed = 67762;
  logic [7:0] m_acc = 0; // Model accumulator
  logic m_c = 0, m_hc = 0, m_z = 0; // Model flags
  logic a_c, a_hc; // Adder carry outputs
  logic [6:0] m_pch = 0; // Model high latch
  ocd_core i_ocd_core (.MCLK(mclk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FILE_ADDR(file_addr),
    .FILE_RD(file_rd), .FILE_WR(file_wr), .FILE_WDATA(file_wdata), .PC_HIGH_LATCH(pch),
    .PTR_SEL(ptr_sel), .PTR_UPDATE_MODE(ptr_mode));
  ocd_file_model i_ocd_file_model (.mclk(mclk), .sys_rst(sys_rst), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .wr_addr(wr_addr),
    .wr_data(wr_data));
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Cut a hang short; the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end
  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Write one word; the response ready comes after a random stall
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    int st;
    aw = 0;
    w = 0;
    st = {$random(seed)} % 3;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    repeat (st) @(posedge mclk);
    bready <= 1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  // Ready rises as the address is taken, so status polls stay four cycles apart and see a skip
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 0;
    rready <= 1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  function automatic logic [7:0] addf(input logic [7:0] x, input logic [7:0] y, input logic ci);
    logic [8:0] s;
    s = x + y + ci;
    a_hc = ({1'b0, x[3:0]} + y[3:0] + ci) > 5'hf;
    a_c = s[8];
    return s[7:0];
  endfunction
  // Reference model of one instruction; updates accumulator, flags and latch
  task automatic model(input logic [13:0] i, input logic [7:0] f, output bit rd, output bit wr, output bit sk,
    output logic [7:0] res);
    logic [3:0] op;
    logic [7:0] k;
    bit fz, fa, fc, tod;
    logic nc;
    op = i[11:8];
    k = i[7:0];
    res = f;
    rd = 1;
    wr = 0;
    sk = 0;
    nc = m_c;
    tod = i[13:12] == 2'h0;
    fz = tod && op inside {[4'h1:4'ha]};
    fa = tod && op inside {4'h2, 4'h7};
    fc = tod && op inside {4'hc, 4'hd};
    case (i[13:12])
      2'h0: begin
        rd = !(op == 4'h1 && !i[7]);
        case (op)
          4'h0: res = m_acc;
          4'h1: res = 8'h0;
          4'h2: res = addf(f, ~m_acc, 1'b1);
          4'h3, 4'hb: res = f - 8'h1;
          4'h4: res = f | m_acc;
          4'h5: res = f & m_acc;
          4'h6: res = f ^ m_acc;
          4'h7: res = addf(f, m_acc, 1'b0);
          4'h9: res = ~f;
          4'ha, 4'hf: res = f + 8'h1;
          4'hc: {res, nc} = {m_c, f};
          4'hd: {nc, res} = {f, m_c};
          4'he: res = {f[3:0], f[7:4]};
          default: ;
        endcase
        sk = op inside {4'hb, 4'hf} && res == 8'h0;
      end
      2'h1: begin
        wr = !op[3];
        res = op[2] ? f | (8'h1 << i[9:7]) : f & ~(8'h1 << i[9:7]);
        sk = op[3] && f[i[9:7]] == op[2];
      end
      default: begin
        fz = op inside {[4'h5:4'he]};
        fa = op inside {[4'hb:4'he]};
        fc = op inside {[4'h5:4'h7]};
        tod = op inside {4'h5, 4'h6, 4'h7, 4'hb, 4'hd};
        rd = tod;
        case (op)
          4'h0: res = k;
          4'h1: m_pch = i[6:0];
          4'h5: {nc, res} = {f, 1'b0};
          4'h6: {res, nc} = {1'b0, f};
          4'h7: {res, nc} = {f[7], f};
          4'h8: res = k | m_acc;
          4'h9: res = k & m_acc;
          4'ha: res = k ^ m_acc;
          4'hb: res = addf(f, ~m_acc, m_c);
          4'hc: res = addf(k, ~m_acc, 1'b1);
          4'hd: res = addf(f, m_acc, m_c);
          default: res = addf(k, m_acc, 1'b0);
        endcase
        if (!tod && op != 4'h1) m_acc = res;
      end
    endcase
    if (tod && i[7]) wr = 1;
    else if (tod) m_acc = res;
    if (fz) m_z = res == 8'h0;
    if (fa) {m_c, m_hc} = {a_c, a_hc};
    if (fc) m_c = nc;
  endtask
  // Load file data and word, start, wait for idle, then compare everything
  task automatic run(input logic [13:0] i, input logic [7:0] f);
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] res;
    bit rd, wr, sk, seen;
    int r0, w0;
    r0 = rd_cnt;
    w0 = wr_cnt;
    seen = 0;
    axi_write(32'h8, {24'h0, f}, r);
    axi_write(32'h0, {18'h0, i}, r);
    axi_write(32'h4, 32'h1, r);
    do begin
      axi_read(32'h4, v, r);
      seen |= v[1];
    end while (v[0] === 1'b1);
    model(i, f, rd, wr, sk, res);
    axi_read(32'hc, v, r);
    check(v[10:0], {m_z, m_hc, m_c, m_acc});
    check(rd_cnt - r0, rd);
    check(wr_cnt - w0, wr);
    if (wr) check({wr_addr, wr_data}, {i[6:0], res});
    check(seen, sk);
    check({pch, ptr_sel, ptr_mode}, {m_pch, i[2:0]});
  endtask
  task automatic results();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [13:0] i;
    logic [7:0] f;
    repeat (5) @(posedge mclk);
    sys_rst <= 0;
    axi_read(32'hc, v, r);
    check(v, 32'h0);
    axi_read(32'h10, v, r);
    check({v, r}, {32'h0, 2'h2});
    axi_write(32'h20, 32'h1, r);
    check(r, 2'h2);
    $display("bus test done");
    for (int n = 0; n < 96; n++) begin
      i = {n % 3 == 2 ? 2'h3 : 2'(n % 3), 4'((n / 3) % 16), 8'($random(seed))};
      f = $random(seed);
      if (i[13:12] == 2'h3 && i[11:8] inside {4'h2, 4'h3, 4'h4, 4'hf}) continue;
      if (i[13:12] == 2'h0 && i[11:8] == 4'h0) i[7] = 1'b1;
      if (i[13:12] == 2'h0 && i[11:8] == 4'h1 && !i[7]) i[6:2] = 5'h0;
      if (i[13:12] == 2'h3 && i[11:8] == 4'h1) i[7] = 1'b1;
      if (n >= 48 && i[13:12] == 2'h0 && i[11:8] == 4'hb) f = 8'h1;
      if (n >= 48 && i[13:12] == 2'h0 && i[11:8] == 4'hf) f = 8'hff;
      run(i, f);
      $display("test %0d done", n);
    end
    results();
  end
endmodule // ocd_core_bench
